// ---- rtl/rru_map.vh ----
// Constants for the rotate instruction unit: register offsets, field positions,
// reset values and opcode patterns.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
`ifndef RRU_MAP_VH
`define RRU_MAP_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define RRU_OFS_CTRL      8'h00
`define RRU_OFS_INSTR     8'h04
`define RRU_OFS_BANK      8'h08
`define RRU_OFS_ACC       8'h0c
`define RRU_OFS_STATUS    8'h10
`define RRU_OFS_IDX_BASE  8'h14
`define RRU_OFS_MEM_ADDR  8'h18
`define RRU_OFS_MEM_DATA  8'h1c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RRU_CTRL_GO       0
`define RRU_CTRL_EXT_EN   1
`define RRU_ST_CARRY      0
`define RRU_ST_ZERO       1
`define RRU_ST_NEG        2
`define RRU_ST_BUSY       8
`define RRU_ST_ILLEGAL    9
`define RRU_OP_DEST_BIT   9
`define RRU_OP_BANK_BIT   8

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RRU_RST_INSTR     16'h0000
`define RRU_RST_BYTE      8'h00
`define RRU_RST_BANK      4'h0
`define RRU_RST_ADDR      12'h000

// ----------------------------------------------------------------------------
// Opcode prefixes (upper six bits) and rotate kinds
// ----------------------------------------------------------------------------
`define RRU_PFX_ROR_PLAIN 6'h10
`define RRU_PFX_ROL_PLAIN 6'h11
`define RRU_PFX_ROR_CARRY 6'h0c
`define RRU_KIND_NONE     2'h0
`define RRU_KIND_ROR      2'h1
`define RRU_KIND_ROL      2'h2
`define RRU_KIND_RORC     2'h3

// ----------------------------------------------------------------------------
// Addressing
// ----------------------------------------------------------------------------
`define RRU_ACCESS_LIMIT  8'h5f
`define RRU_ACCESS_HI     4'hf
`define RRU_ACCESS_LO     4'h0

`endif

// ---- rtl/rru_rotator.v ----
// Combinational rotate stage with result flags.
// Assumes the caller holds kind, operand and carry stable for the phase.
`timescale 1ns/1ps
`include "rru_map.vh"

module rru_rotator (
  // Operation select and operand
  input  wire [1:0] kind_i,
  input  wire [7:0] operand_i,
  input  wire       carry_i,
  // Result and flags
  output reg  [7:0] result_o,
  output reg        carry_o,
  output wire       zero_o,
  output wire       neg_o
);

  // --------------------------------------------------------------------------
  // Rotation
  // --------------------------------------------------------------------------
  always @* begin
    // Plain rotates keep carry
    carry_o  = carry_i;
    result_o = operand_i;
    case (kind_i)
      `RRU_KIND_ROR: result_o = {operand_i[0], operand_i[7:1]};
      `RRU_KIND_ROL: result_o = {operand_i[6:0], operand_i[7]};
      `RRU_KIND_RORC: begin
        result_o = {carry_i, operand_i[7:1]};
        carry_o  = operand_i[0];
      end
      default: result_o = operand_i;
    endcase
  end

  // Flags from the rotated byte
  assign zero_o = (result_o == 8'h00);
  assign neg_o  = result_o[7];

endmodule // rru_rotator

// ---- rtl/rru_core.v ----
// Rotate instruction unit: decodes one rotate opcode, reads a file register,
// rotates it and writes accumulator or file register in four phases.
// Assumes a classic Wishbone master on the register side and a single clock.
//
// What this block does
// - Plain right rotate wraps bit 0 to 7
// - Decode plain right rotate from prefix 010000
// - Plain rotate updates N and Z only
// - Destination bit 0 writes the accumulator
// - Destination bit 1 writes file register back
// - Bank bit 0 uses access bank
// - Bank bit 1 uses bank select register
// - Extended mode, bank 0, f<=95 indexes literally
// - One word, one instruction cycle
// - Decode, read, process, write in four phases
// - Operand 0..255, d and a single bits
// - Plain left rotate, prefix 010001, N Z
// - Right rotate through carry updates C N Z
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "rru_map.vh"

module rru_core #(
  parameter ADDR_W = 12                          // Data space address width
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Execution status
  output reg         busy_o,
  output reg         done_o
);

  // --------------------------------------------------------------------------
  // Phase states, one-hot
  // --------------------------------------------------------------------------
  localparam [4:0] ST_IDLE    = 5'h01;
  localparam [4:0] ST_DECODE  = 5'h02;           // phase_decode
  localparam [4:0] ST_READ    = 5'h04;           // phase_read
  localparam [4:0] ST_PROCESS = 5'h08;           // phase_process
  localparam [4:0] ST_WRITE   = 5'h10;           // phase_write
  localparam       DEPTH      = 1 << ADDR_W;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg [4:0]        state_q;                      // Current phase
  reg [4:0]        state_d;                      // Next phase
  reg [15:0]       instr_q;                      // Opcode word
  reg [3:0]        bank_q;                       // bank_select_register
  reg [7:0]        acc_q;                        // Accumulator
  reg              carry_q;                      // Carry flag
  reg              zero_q;                       // Zero flag
  reg              neg_q;                        // Negative flag
  reg              ext_en_q;                     // Extended instruction set
  reg              illegal_q;                    // Last opcode was not a rotate
  reg [ADDR_W-1:0] idx_base_q;                   // Base for indexed offsets
  reg [ADDR_W-1:0] mem_ptr_q;                    // Software memory pointer
  reg [1:0]        kind_q;                       // Decoded rotate kind
  reg              dest_f_q;                     // Write back to file register
  reg [ADDR_W-1:0] addr_q;                       // Operand address
  reg [7:0]        operand_q;                    // Byte read in phase_read
  reg [7:0]        result_q;                     // Byte computed in phase_process
  reg              carry_res_q;                  // Carry computed in phase_process
  reg              zero_res_q;                   // Zero computed in phase_process
  reg              neg_res_q;                    // Negative computed in phase_process
  reg [7:0]        mem [0:DEPTH-1];              // File register space

  wire [7:0]       rot_result;                   // Rotator output
  wire             rot_carry;                    // Rotator carry out
  wire             rot_zero;                     // Rotator zero
  wire             rot_neg;                      // Rotator negative
  wire             bus_req;                      // New request this cycle
  wire             bus_wr;                       // New write this cycle
  wire             idle;                         // No instruction in flight
  wire             mem_wr_sw;                    // Software writes memory
  wire             mem_wr_hw;                    // Instruction writes memory

  // --------------------------------------------------------------------------
  // Opcode classification, reused for decode and the illegal flag
  // --------------------------------------------------------------------------
  function [1:0] rot_kind;
    input [15:0] op;
    begin
      case (op[15:10])
        `RRU_PFX_ROR_PLAIN: rot_kind = `RRU_KIND_ROR;
        `RRU_PFX_ROL_PLAIN: rot_kind = `RRU_KIND_ROL;
        `RRU_PFX_ROR_CARRY: rot_kind = `RRU_KIND_RORC;
        default:            rot_kind = `RRU_KIND_NONE;
      endcase
    end
  endfunction

  // Operand address from the a bit and the 8-bit field, which spans 0..255
  function [ADDR_W-1:0] op_addr;
    input [15:0]       op;
    input [3:0]        bank;
    input              ext;
    input [ADDR_W-1:0] base;
    begin
      if (op[`RRU_OP_BANK_BIT]) begin
        op_addr = {bank, op[7:0]};
      end else if (ext && (op[7:0] <= `RRU_ACCESS_LIMIT)) begin
        op_addr = base + {{(ADDR_W-8){1'b0}}, op[7:0]};
      end else if (op[7:0] <= `RRU_ACCESS_LIMIT) begin
        op_addr = {`RRU_ACCESS_LO, op[7:0]};
      end else begin
        op_addr = {`RRU_ACCESS_HI, op[7:0]};
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // Rotate stage
  // --------------------------------------------------------------------------
  rru_rotator u_rot (
    .kind_i    (kind_q),
    .operand_i (operand_q),
    .carry_i   (carry_q),
    .result_o  (rot_result),
    .carry_o   (rot_carry),
    .zero_o    (rot_zero),
    .neg_o     (rot_neg)
  );

  // --------------------------------------------------------------------------
  // Bus qualifiers
  // --------------------------------------------------------------------------
  // Ack is given one cycle after the request and dropped the next, so a held
  // request is acted on exactly once.
  assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr    = bus_req & wb_we_i & wb_sel_i[0];
  assign idle      = state_q[0];
  // Software memory writes are dropped while an instruction is in flight
  assign mem_wr_sw = bus_wr & idle & (wb_adr_i == `RRU_OFS_MEM_DATA);
  assign mem_wr_hw = state_q[4] & dest_f_q & (kind_q != `RRU_KIND_NONE);

  // --------------------------------------------------------------------------
  // Phase sequencer: one instruction cycle is four clocks
  // --------------------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (bus_wr && (wb_adr_i == `RRU_OFS_CTRL) && wb_dat_i[`RRU_CTRL_GO]) begin
          state_d = ST_DECODE;
        end
      end
      ST_DECODE:  state_d = ST_READ;
      ST_READ:    state_d = ST_PROCESS;
      ST_PROCESS: state_d = ST_WRITE;
      ST_WRITE:   state_d = ST_IDLE;
      default:    state_d = ST_IDLE;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // --------------------------------------------------------------------------
  // Datapath through the four phases
  // --------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      kind_q      <= `RRU_KIND_NONE;
      dest_f_q    <= 1'b1;
      addr_q      <= {ADDR_W{1'b0}};
      operand_q   <= `RRU_RST_BYTE;
      result_q    <= `RRU_RST_BYTE;
      carry_res_q <= 1'b0;
      zero_res_q  <= 1'b0;
      neg_res_q   <= 1'b0;
    end else begin
      // Decode the whole word; single-word instructions only
      if (state_q[1]) begin
        kind_q   <= rot_kind(instr_q);
        dest_f_q <= instr_q[`RRU_OP_DEST_BIT];
        addr_q   <= op_addr(instr_q, bank_q, ext_en_q, idx_base_q);
      end
      // Read the file register
      if (state_q[2]) begin
        operand_q <= mem[addr_q];
      end
      // Rotate and derive flags
      if (state_q[3]) begin
        result_q    <= rot_result;
        carry_res_q <= rot_carry;
        zero_res_q  <= rot_zero;
        neg_res_q   <= rot_neg;
      end
    end
  end

  // --------------------------------------------------------------------------
  // File register space: instruction write wins, bus write is locked out
  // --------------------------------------------------------------------------
  // No reset on the array so it can map to block RAM.
  always @(posedge clk_i) begin
    if (mem_wr_hw) begin
      mem[addr_q] <= result_q;
    end else if (mem_wr_sw) begin
      mem[mem_ptr_q] <= wb_dat_i[7:0];
    end
  end

  // --------------------------------------------------------------------------
  // Software registers and architectural results
  // --------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      instr_q    <= `RRU_RST_INSTR;
      bank_q     <= `RRU_RST_BANK;
      acc_q      <= `RRU_RST_BYTE;
      carry_q    <= 1'b0;
      zero_q     <= 1'b0;
      neg_q      <= 1'b0;
      ext_en_q   <= 1'b0;
      illegal_q  <= 1'b0;
      idx_base_q <= {ADDR_W{1'b0}};
      mem_ptr_q  <= {ADDR_W{1'b0}};
    end else begin
      // Writes that shape an instruction are ignored while one is in flight
      if (bus_wr && idle) begin
        case (wb_adr_i)
          `RRU_OFS_CTRL:     ext_en_q   <= wb_dat_i[`RRU_CTRL_EXT_EN];
          `RRU_OFS_INSTR:    instr_q    <= wb_dat_i[15:0];
          `RRU_OFS_BANK:     bank_q     <= wb_dat_i[3:0];
          `RRU_OFS_ACC:      acc_q      <= wb_dat_i[7:0];
          `RRU_OFS_IDX_BASE: idx_base_q <= wb_dat_i[ADDR_W-1:0];
          `RRU_OFS_MEM_ADDR: mem_ptr_q  <= wb_dat_i[ADDR_W-1:0];
          `RRU_OFS_STATUS: begin
            carry_q <= wb_dat_i[`RRU_ST_CARRY];
            zero_q  <= wb_dat_i[`RRU_ST_ZERO];
            neg_q   <= wb_dat_i[`RRU_ST_NEG];
          end
          default: ;
        endcase
      end
      // Illegal flag is refreshed by each decode
      if (state_q[1]) begin
        illegal_q <= (rot_kind(instr_q) == `RRU_KIND_NONE);
      end
      // Write phase commits result and flags
      if (state_q[4] && (kind_q != `RRU_KIND_NONE)) begin
        if (!dest_f_q) begin
          acc_q <= result_q;
        end
        zero_q <= zero_res_q;
        neg_q  <= neg_res_q;
        if (kind_q == `RRU_KIND_RORC) begin
          carry_q <= carry_res_q;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Wishbone answer: registered ack and read data
  // --------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req) begin
        wb_dat_o <= 32'h0000_0000;   // Unmapped reads return zero
        case (wb_adr_i)
          `RRU_OFS_CTRL:     wb_dat_o[`RRU_CTRL_EXT_EN] <= ext_en_q;
          `RRU_OFS_INSTR:    wb_dat_o[15:0]             <= instr_q;
          `RRU_OFS_BANK:     wb_dat_o[3:0]              <= bank_q;
          `RRU_OFS_ACC:      wb_dat_o[7:0]              <= acc_q;
          `RRU_OFS_IDX_BASE: wb_dat_o[ADDR_W-1:0]       <= idx_base_q;
          `RRU_OFS_MEM_ADDR: wb_dat_o[ADDR_W-1:0]       <= mem_ptr_q;
          `RRU_OFS_MEM_DATA: wb_dat_o[7:0]              <= mem[mem_ptr_q];
          `RRU_OFS_STATUS: begin
            wb_dat_o[`RRU_ST_CARRY]   <= carry_q;
            wb_dat_o[`RRU_ST_ZERO]    <= zero_q;
            wb_dat_o[`RRU_ST_NEG]     <= neg_q;
            wb_dat_o[`RRU_ST_BUSY]    <= ~idle;
            wb_dat_o[`RRU_ST_ILLEGAL] <= illegal_q;
          end
          default: ;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Status outputs
  // --------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      busy_o <= ~state_d[0];
      done_o <= state_q[4];          // One pulse per completed instruction cycle
    end
  end

endmodule // rru_core

// ---- sim/rru_core_monitor.sv ----
// Checker for the rotate unit: bus handshake and instruction timing.
// Assumes it is bound to rru_core and sees only that module's ports.
`timescale 1ns/1ps
`include "rru_map.vh"

module rru_monitor (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Bus inputs
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  // Bus outputs
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Execution status
  input wire logic        busy_o,
  input wire logic        done_o
);
  // ---------------------------------------------------------------------------
  // Steps of an access and of one instruction
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Request that the slave takes at this edge
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Start write to control; a busy unit refuses it, so idle is required
  sequence go_s;
    req_s ##0 (wb_we_i && wb_sel_i[0] && wb_dat_i[`RRU_CTRL_GO] && wb_adr_i == `RRU_OFS_CTRL && !busy_o);
  endsequence
  // Four phases busy, then one done pulse
  sequence run_s;
    busy_o [*4] ##1 (!busy_o && done_o);
  endsequence
  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  ack_answer_a: assert property (req_s |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  inst_cycle_a: assert property (go_s |=> run_s)
    else $error("instruction cycle not four phases");
  busy_cause_a: assert property ($rose(busy_o) |-> $past(wb_we_i && wb_adr_i == `RRU_OFS_CTRL))
    else $error("busy without start write");
  done_cause_a: assert property (done_o |-> ($past(busy_o) && !busy_o && !$past(done_o)))
    else $error("done not right after busy");
  upper_zero_a: assert property (wb_ack_o |-> (wb_dat_o[31:16] == 16'h0000))
    else $error("upper read bits not zero");
  reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> (!wb_ack_o && !busy_o && !done_o))
    else $error("outputs active after reset");
endmodule // rru_monitor

bind rru_core rru_monitor mon (
  .clk_i    (clk_i),
  .rst_i    (rst_i),
  .wb_cyc_i (wb_cyc_i),
  .wb_stb_i (wb_stb_i),
  .wb_we_i  (wb_we_i),
  .wb_adr_i (wb_adr_i),
  .wb_sel_i (wb_sel_i),
  .wb_dat_i (wb_dat_i),
  .wb_dat_o (wb_dat_o),
  .wb_ack_o (wb_ack_o),
  .busy_o   (busy_o),
  .done_o   (done_o)
);

// ---- sim/test_rotate_instruction_unit.sv ----
// Self-checking bench for the rotate unit, driven over its register bus.
// Assumes rru_core with the register map of rru_map.vh and a 100 MHz clock.
`timescale 1ns/1ps
`include "rru_map.vh"

module test_rotate_instruction_unit;
  // ---------------------------------------------------------------------------
  // Signals and counters
  // ---------------------------------------------------------------------------
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        busy_o;
  logic        done_o;
  int          err_total = 0;
  int          n_checks  = 0;

  rru_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o), .done_o(done_o));

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One classic cycle; held until ack is sampled, then released
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (n == 20) begin
      err_total++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask

  // Data memory byte access through the pointer
  task automatic mem(input logic [11:0] a, input logic [7:0] v);
    wr(`RRU_OFS_MEM_ADDR, {20'h0, a});
    wr(`RRU_OFS_MEM_DATA, {24'h0, v});
  endtask

  task automatic memchk(input logic [11:0] a, input logic [7:0] e);
    wr(`RRU_OFS_MEM_ADDR, {20'h0, a});
    rdchk("mem", `RRU_OFS_MEM_DATA, {24'h0, e});
  endtask

  // Waits for done; the count of edges after the start ack is fixed by the phases
  task automatic wait_done(output int n);
    for (n = 1; n <= 20; n++) begin
      @(posedge clk_i);
      if (done_o === 1'b1) break;
    end
    if (n > 20) begin
      err_total++;
      finish_test();
    end
  endtask

  task automatic run(input logic [15:0] op, input logic ext);
    int n;
    wr(`RRU_OFS_INSTR, {16'h0, op});
    wr(`RRU_OFS_CTRL, {30'h0, ext, 1'b1});
    wait_done(n);
    chk("phases", 32'd4, n);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic s_reset;
    rdchk("instr", `RRU_OFS_INSTR, 32'h0);
    rdchk("acc", `RRU_OFS_ACC, 32'h0);
    rdchk("status", `RRU_OFS_STATUS, 32'h0);
    rdchk("bank", `RRU_OFS_BANK, 32'h0);
    wr(8'h20, 32'hffff_ffff);
    rdchk("unmapped", 8'h20, 32'h0);
  endtask

  // Banked operand, result back to memory, carry kept
  task automatic s_ror_file;
    wr(`RRU_OFS_BANK, 32'h3);
    mem(12'h3a5, 8'hd7);
    wr(`RRU_OFS_STATUS, 32'h1);
    run(16'h43a5, 1'b0);
    memchk(12'h3a5, 8'heb);
    rdchk("acc", `RRU_OFS_ACC, 32'h0);
    rdchk("status", `RRU_OFS_STATUS, 32'h5);
  endtask

  // Access bank ignores the bank select, result to accumulator
  task automatic s_ror_acc;
    mem(12'h010, 8'h01);
    mem(12'h310, 8'h02);
    run(16'h4010, 1'b0);
    rdchk("acc", `RRU_OFS_ACC, 32'h80);
    memchk(12'h010, 8'h01);
  endtask

  // Highest operand maps to the upper access bank; zero result
  task automatic s_ror_zero;
    mem(12'hfff, 8'h00);
    run(16'h42ff, 1'b0);
    memchk(12'hfff, 8'h00);
    rdchk("acc", `RRU_OFS_ACC, 32'h80);
    rdchk("status", `RRU_OFS_STATUS, 32'h3);
  endtask

  // Indexed offsets up to 0x5f only, 0x60 stays in the access bank
  task automatic s_ext;
    wr(`RRU_OFS_IDX_BASE, 32'h200);
    mem(12'h25f, 8'h02);
    mem(12'hf60, 8'h04);
    run(16'h405f, 1'b1);
    rdchk("acc", `RRU_OFS_ACC, 32'h01);
    run(16'h4060, 1'b1);
    rdchk("acc", `RRU_OFS_ACC, 32'h02);
  endtask

  task automatic s_rol;
    mem(12'h322, 8'hab);
    run(16'h4722, 1'b0);
    memchk(12'h322, 8'h57);
    rdchk("status", `RRU_OFS_STATUS, 32'h1);
  endtask

  // Carry out of bit 0 returns into bit 7 on the second pass
  task automatic s_rorc;
    wr(`RRU_OFS_STATUS, 32'h0);
    mem(12'h3e6, 8'he7);
    run(16'h31e6, 1'b0);
    rdchk("acc", `RRU_OFS_ACC, 32'h73);
    rdchk("status", `RRU_OFS_STATUS, 32'h1);
    run(16'h31e6, 1'b0);
    rdchk("acc", `RRU_OFS_ACC, 32'hf3);
    rdchk("status", `RRU_OFS_STATUS, 32'h5);
  endtask

  // Non-rotate opcode writes nothing
  task automatic s_illegal;
    run(16'hffff, 1'b0);
    rdchk("acc", `RRU_OFS_ACC, 32'hf3);
    rdchk("status", `RRU_OFS_STATUS, 32'h205);
  endtask

  // A write while executing is refused; bank is not touched by the instruction,
  // so a landed write would show there
  task automatic s_busy;
    int n;
    wr(`RRU_OFS_INSTR, 32'h4010);
    wr(`RRU_OFS_CTRL, 32'h1);
    wr(`RRU_OFS_BANK, 32'h5);
    wait_done(n);
    rdchk("acc", `RRU_OFS_ACC, 32'h80);
    rdchk("bank", `RRU_OFS_BANK, 32'h3);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    s_reset();
    s_ror_file();
    s_ror_acc();
    s_ror_zero();
    s_ext();
    s_rol();
    s_rorc();
    s_illegal();
    s_busy();
    finish_test();
  end
endmodule // test_rotate_instruction_unit
